// [dtc_timing_ctrl.sv]
// DRAM timing control: timing register on APB and a leadoff/burst sequencer.
// Assumes an APB master on core_clk_i and a memory front end issuing requests.
// The front end names the kind of each access; rows are not tracked here.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
module dtc_timing_ctrl (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic access_req_i,
    input wire logic access_write_i,
    input wire logic [1:0] access_kind_i,
    input wire logic access_pipelined_i,
    input wire logic access_ras_active_i,
    output logic access_busy_o,
    output logic data_beat_o,
    output logic access_done_o,
    output logic [4:0] leadoff_count_o
);
    ////////////////////////////////////////////////////////////////////////
    // Register file and APB slave.
    //
    // Map, one word each, upper bits zero:
    //   0x58 timing, fields below.
    //   0x5C control: bit 0 SDRAM, bit 1 ECC.
    //   0x60 status, read only: bit 0 busy,
    //   bits 12:8 last leadoff count.
    // Status writes are accepted and dropped.
    // Upper pwdata bits are ignored.
    //
    // Timing fields, 1 faster except bit 5 on a pipelined SDRAM page hit:
    //   bit 0 address wait state.
    //   bit 1 EDO RAS-to-CAS delay.
    //   bit 2 EDO precharge.
    //   bit 3 EDO read burst rate.
    //   bit 4 EDO write burst rate.
    //   bit 5 SDRAM CAS latency.
    //   bit 6 SDRAM RAS-to-CAS delay.
    //   bit 7 SDRAM precharge.
    //
    // Reset leaves all fields slow, which is
    // safe for any memory fitted.
    // Bit 1 should stay 0 on EDO parts: the
    // short delay erodes access margin.
    //
    logic [7:0] dram_access_timing;
    logic [7:0] next_timing;
    logic [1:0] ctrl;
    logic [1:0] next_ctrl;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic setup_phase;
    logic access_phase;
    logic addr_hit;
    logic [31:0] read_mux;

    // Sequencer state, declared here because the status read needs it.
    dtc_pkg::dtc_state_e state;
    dtc_pkg::dtc_state_e next_state;
    logic [4:0] last_leadoff;
    logic [4:0] next_last_leadoff;

    // Bus timing seen by the master:
    //   setup: read data latched.
    //   access: pready, one cycle, no wait.
    //   end of access: write stored.
    // Unmapped addresses answer with pslverr
    // so a bad pointer cannot hang the bus.
    // The pslverr flag shares pready's timing.
    // Reads of status see live state.
    //
    // Read data is captured in the setup cycle so that prdata is a flop and
    // the slave can answer with no wait state.
    always_comb begin
        setup_phase = psel && !penable;
        access_phase = psel && penable && pready;
        addr_hit = (paddr == dtc_pkg::ADDR_TIMING) || (paddr == dtc_pkg::ADDR_CTRL)
            || (paddr == dtc_pkg::ADDR_STATUS);
        read_mux = 32'h0000_0000;
        case (paddr)
            dtc_pkg::ADDR_TIMING: read_mux[7:0] = dram_access_timing;
            dtc_pkg::ADDR_CTRL: read_mux[1:0] = ctrl;
            dtc_pkg::ADDR_STATUS: begin
                read_mux[dtc_pkg::ST_BUSY] = (state != dtc_pkg::DTC_IDLE);
                read_mux[dtc_pkg::ST_COUNT_LSB +: 5] = last_leadoff;
            end
            default: read_mux = 32'h0000_0000;
        endcase
        // Answer follows setup only, so
        // back-to-back transfers just work.
        next_pready = setup_phase;
        next_pslverr = setup_phase && !addr_hit;
        next_prdata = prdata;
        if (setup_phase) begin
            next_prdata = (pwrite || !addr_hit) ? 32'h0000_0000 : read_mux;
        end
        // Hold unless a write completes.
        next_timing = dram_access_timing;
        next_ctrl = ctrl;
        // Writes take effect only at the completing edge of the access phase.
        if (access_phase && pwrite) begin
            if (paddr == dtc_pkg::ADDR_TIMING) begin
                next_timing = pwdata[7:0];
            end
            if (paddr == dtc_pkg::ADDR_CTRL) begin
                next_ctrl = pwdata[1:0];
            end
        end
    end

    // Register stage; reset is all slow.
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            dram_access_timing <= dtc_pkg::TIMING_RESET;
            ctrl <= dtc_pkg::CTRL_RESET;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            dram_access_timing <= next_timing;
            ctrl <= next_ctrl;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pure logic; its result matters only in
    // the cycle a request is taken. Kind 3
    // counts as a page miss, the safer case.
    // The leadoff rules live in there.
    //
    // Leadoff count from the live settings, sampled only when a request is
    // taken, so a later register write cannot disturb the running access.
    logic [4:0] calc_count;

    dtc_leadoff_calc u_calc (
        .is_sdram_i(ctrl[dtc_pkg::CT_SDRAM]),
        .ecc_en_i(ctrl[dtc_pkg::CT_ECC]),
        .timing_i(dram_access_timing),
        .kind_i(access_kind_i),
        .pipelined_i(access_pipelined_i),
        .ras_active_i(access_ras_active_i),
        .count_o(calc_count)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: leadoff interval, then the remaining burst transfers.
    //
    // One access, from the taking edge:
    //   cycle 1: busy and count published.
    //   cycle N+1: first beat, N the leadoff.
    //   then every B cycles: three more.
    //   last beat: done, busy drops.
    // The counter flags its last clock and
    // the beat flop adds one, hence N+1.
    // A new request may be taken at the
    // edge ending done: no clock lost.
    // Requests while busy are dropped; the
    // front end holds its request until
    // busy is seen low.
    // Burst length is fixed at four.
    // Pipelined accesses share this path.
    //
    logic [4:0] beat_clocks;
    logic [4:0] next_beat_clocks;
    logic [1:0] beats_left;
    logic [1:0] next_beats_left;
    logic cnt_load;
    logic [4:0] cnt_value;
    logic cnt_last;
    logic next_beat;
    logic next_done;
    logic req_taken;

    // Five bits cover the longest leadoff,
    // slow settings and ECC included.
    dtc_cycle_counter #(
        .WIDTH(5)
    ) u_counter (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .load_i(cnt_load),
        .load_value_i(cnt_value),
        .last_o(cnt_last)
    );

    // All an access needs is captured when
    // it is taken, so a register write
    // mid-access cannot bend its timing.
    // The rate resets to slow EDO, unused.
    //
    // The burst rate is frozen at request time together with the leadoff.
    always_comb begin
        next_state = state;
        next_beat_clocks = beat_clocks;
        next_beats_left = beats_left;
        next_last_leadoff = last_leadoff;
        cnt_load = 1'b0;
        cnt_value = calc_count;
        next_beat = 1'b0;
        next_done = 1'b0;
        req_taken = (state == dtc_pkg::DTC_IDLE) && access_req_i;
        // Only idle takes a request.
        case (state)
            dtc_pkg::DTC_IDLE: begin
                if (access_req_i) begin
                    cnt_load = 1'b1;
                    next_last_leadoff = calc_count;
                    next_beats_left = 2'(dtc_pkg::BURST_LEN - 1);
                    if (ctrl[dtc_pkg::CT_SDRAM]) begin
                        next_beat_clocks = dtc_pkg::SD_BURST;
                    end else if (access_write_i ? dram_access_timing[dtc_pkg::TM_WR_BURST]
                        : dram_access_timing[dtc_pkg::TM_RD_BURST]) begin
                        next_beat_clocks = dtc_pkg::EDO_BURST_FAST;
                    end else begin
                        next_beat_clocks = dtc_pkg::EDO_BURST_SLOW;
                    end
                    next_state = dtc_pkg::DTC_LEAD;
                end
            end
            // Last leadoff clock: first beat.
            dtc_pkg::DTC_LEAD: begin
                if (cnt_last) begin
                    next_beat = 1'b1;
                    cnt_load = 1'b1;
                    cnt_value = beat_clocks;
                    next_state = dtc_pkg::DTC_BURST;
                end
            end
            // Fourth beat also ends the access.
            dtc_pkg::DTC_BURST: begin
                if (cnt_last) begin
                    next_beat = 1'b1;
                    next_beats_left = beats_left - 2'h1;
                    if (beats_left == 2'h1) begin
                        next_done = 1'b1;
                        next_state = dtc_pkg::DTC_IDLE;
                    end else begin
                        cnt_load = 1'b1;
                        cnt_value = beat_clocks;
                    end
                end
            end
            default: begin
                next_state = dtc_pkg::DTC_IDLE;
            end
        endcase
    end

    // Ports come from flops fed by the next
    // state, so each shows the state it names.
    // Busy thus drops with the last beat.
    // Done and last beat share a cycle.
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            state <= dtc_pkg::DTC_IDLE;
            beat_clocks <= dtc_pkg::EDO_BURST_SLOW;
            beats_left <= 2'h0;
            last_leadoff <= 5'h00;
            access_busy_o <= 1'b0;
            data_beat_o <= 1'b0;
            access_done_o <= 1'b0;
            leadoff_count_o <= 5'h00;
        end else begin
            state <= next_state;
            beat_clocks <= next_beat_clocks;
            beats_left <= next_beats_left;
            last_leadoff <= next_last_leadoff;
            access_busy_o <= (next_state != dtc_pkg::DTC_IDLE);
            data_beat_o <= next_beat;
            access_done_o <= next_done;
            leadoff_count_o <= next_last_leadoff;
        end
    end
endmodule

// [dtc_pkg.sv]
// Shared constants for the DRAM timing control block.
// Assumes a 32-bit APB register bus and a single 20 MHz core clock.
package dtc_pkg;
    // Clock rate of core_clk_i in kHz.
    localparam int CLK_KHZ = 20000;

    // Register byte addresses.
    localparam logic [7:0] ADDR_TIMING = 8'h58;
    localparam logic [7:0] ADDR_CTRL = 8'h5C;
    localparam logic [7:0] ADDR_STATUS = 8'h60;

    // Field positions of dram_access_timing.
    localparam int TM_ADDR_WAIT = 0;
    localparam int TM_EDO_RCD = 1;
    localparam int TM_EDO_RPT = 2;
    localparam int TM_RD_BURST = 3;
    localparam int TM_WR_BURST = 4;
    localparam int TM_SD_CL = 5;
    localparam int TM_SD_RCD = 6;
    localparam int TM_SD_RPT = 7;
    localparam logic [7:0] TIMING_RESET = 8'h00;

    // Field positions of the control register.
    localparam int CT_SDRAM = 0;
    localparam int CT_ECC = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;

    // Field positions of the status register.
    localparam int ST_BUSY = 0;
    localparam int ST_COUNT_LSB = 8;

    // Access kinds.
    localparam logic [1:0] KIND_PAGE_HIT = 2'h0;
    localparam logic [1:0] KIND_ROW_MISS = 2'h1;
    localparam logic [1:0] KIND_PAGE_MISS = 2'h2;

    // Base leadoff counts at the fastest settings but the slow EDO RAS-to-CAS delay, in clocks.
    localparam logic [4:0] EDO_FIRST_PH = 5'h08;
    localparam logic [4:0] EDO_FIRST_RM = 5'h0A;
    localparam logic [4:0] EDO_FIRST_PM = 5'h0D;
    localparam logic [4:0] EDO_PIPE_PH = 5'h02;
    localparam logic [4:0] EDO_PIPE_RM = 5'h06;
    localparam logic [4:0] EDO_PIPE_PM = 5'h08;
    localparam logic [4:0] SD_FIRST_PH = 5'h08;
    localparam logic [4:0] SD_FIRST_RM = 5'h0A;
    localparam logic [4:0] SD_FIRST_PM = 5'h0C;
    localparam logic [4:0] SD_PIPE_PH = 5'h02;
    localparam logic [4:0] SD_PIPE_RM = 5'h04;
    localparam logic [4:0] SD_PIPE_PM = 5'h05;

    // Clocks per subsequent burst transfer.
    localparam logic [4:0] EDO_BURST_FAST = 5'h02;
    localparam logic [4:0] EDO_BURST_SLOW = 5'h03;
    localparam logic [4:0] SD_BURST = 5'h01;

    // Transfers in one burst.
    localparam int BURST_LEN = 4;

    typedef enum logic [2:0] {
        DTC_IDLE = 3'b001,
        DTC_LEAD = 3'b010,
        DTC_BURST = 3'b100
    } dtc_state_e;
endpackage

// [dtc_leadoff_calc.sv]
// Leadoff clock count from the timing settings and the access kind.
// Assumes settings and request inputs are stable in the cycle it is read.
`timescale 1ns/1ps
module dtc_leadoff_calc (
    input wire logic is_sdram_i,
    input wire logic ecc_en_i,
    input wire logic [7:0] timing_i,
    input wire logic [1:0] kind_i,
    input wire logic pipelined_i,
    input wire logic ras_active_i,
    output logic [4:0] count_o
);
    ////////////////////////////////////////////////////////////////////////
    // Slow settings add a clock each (slow CL on a pipelined SDRAM page hit takes one off), address wait up to three; EDO miss bases assume slow RAS-to-CAS.
    logic slow;
    logic [4:0] base;
    logic [4:0] extra;
    always_comb begin
        slow = !timing_i[dtc_pkg::TM_ADDR_WAIT];
        base = 5'h00;
        extra = 5'h00;
        if (is_sdram_i) begin
            case (kind_i)
                dtc_pkg::KIND_PAGE_HIT: begin
                    base = pipelined_i ? dtc_pkg::SD_PIPE_PH : dtc_pkg::SD_FIRST_PH;
                    // Longer latency lengthens first leadoff but shortens the pipelined one.
                    if (pipelined_i) begin
                        base = base - {4'h0, !timing_i[dtc_pkg::TM_SD_CL]};
                    end else begin
                        extra = {4'h0, !timing_i[dtc_pkg::TM_SD_CL]};
                    end
                    extra = extra + {4'h0, slow};
                end
                dtc_pkg::KIND_ROW_MISS: begin
                    base = pipelined_i ? dtc_pkg::SD_PIPE_RM : dtc_pkg::SD_FIRST_RM;
                    extra = {4'h0, !timing_i[dtc_pkg::TM_SD_CL]}
                        + {4'h0, !timing_i[dtc_pkg::TM_SD_RCD]}
                        + {3'h0, slow, 1'b0};
                end
                default: begin
                    base = pipelined_i ? dtc_pkg::SD_PIPE_PM : dtc_pkg::SD_FIRST_PM;
                    extra = {4'h0, !timing_i[dtc_pkg::TM_SD_CL]}
                        + {4'h0, !timing_i[dtc_pkg::TM_SD_RCD]}
                        + {4'h0, !timing_i[dtc_pkg::TM_SD_RPT]}
                        + {3'h0, slow, 1'b0} + {4'h0, slow};
                end
            endcase
        end else begin
            case (kind_i)
                dtc_pkg::KIND_PAGE_HIT: begin
                    base = pipelined_i ? dtc_pkg::EDO_PIPE_PH : dtc_pkg::EDO_FIRST_PH;
                    extra = {4'h0, slow};
                end
                dtc_pkg::KIND_ROW_MISS: begin
                    base = pipelined_i ? dtc_pkg::EDO_PIPE_RM : dtc_pkg::EDO_FIRST_RM;
                    // The tabulated base assumes the 3-clock delay.
                    base = base - {4'h0, timing_i[dtc_pkg::TM_EDO_RCD]};
                    extra = pipelined_i ? {4'h0, slow} : {3'h0, slow, 1'b0};
                end
                default: begin
                    base = pipelined_i ? dtc_pkg::EDO_PIPE_PM : dtc_pkg::EDO_FIRST_PM;
                    base = base - {4'h0, timing_i[dtc_pkg::TM_EDO_RCD]};
                    extra = {4'h0, !timing_i[dtc_pkg::TM_EDO_RPT]}
                        + (pipelined_i ? {4'h0, slow} : {3'h0, slow, 1'b0});
                end
            endcase
        end
        // A live row strobe must be negated first on a non-pipelined row miss.
        if (kind_i == dtc_pkg::KIND_ROW_MISS && !pipelined_i && ras_active_i) begin
            extra = extra + 5'h01;
        end
        if (ecc_en_i) begin
            extra = extra + 5'h01;
        end
        count_o = base + extra;
    end
endmodule

// [dtc_cycle_counter.sv]
// Loadable down counter that flags the last clock of a loaded interval.
// Assumes a load value of at least one.
`timescale 1ns/1ps
module dtc_cycle_counter #(
    parameter int WIDTH = 5
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic load_i,
    input wire logic [WIDTH-1:0] load_value_i,
    output logic last_o
);
    ////////////////////////////////////////////////////////////////////////
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;

    // A load wins over the count, so back-to-back intervals lose no clock.
    always_comb begin
        next_count = count;
        if (load_i) begin
            next_count = load_value_i;
        end else if (count != '0) begin
            next_count = count - WIDTH'(1);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign last_o = (count == WIDTH'(1));
endmodule

// [dtc_timing_monitor.sv]
// Checker for the port behaviour of the DRAM timing control block.
// Assumes it is bound to dtc_timing_ctrl and sees only that module's ports.
`timescale 1ns/1ps
module dtc_timing_monitor (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic access_req_i,
    input wire logic access_busy_o,
    input wire logic data_beat_o,
    input wire logic access_done_o,
    input wire logic [4:0] leadoff_count_o
);
    // One clock domain, so reset silences every check in one place.
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (sys_rst_i);
    ////////////////////////////////////////////////
    // Register bus answers in the cycle after setup and only in an access phase.
    property p_ready; psel && !penable |=> pready; endproperty
    a_ready: assert property (p_ready) else $error("No answer after setup.");
    property p_phase; pready |-> psel && penable; endproperty
    a_phase: assert property (p_phase) else $error("Answer outside access phase.");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("Error flag without answer.");
    // An idle block takes a request at once; its count stays fixed meanwhile.
    property p_take; access_req_i && !access_busy_o |=> access_busy_o; endproperty
    a_take: assert property (p_take) else $error("Request not taken.");
    property p_hold; access_busy_o && $past(access_busy_o) |-> $stable(leadoff_count_o); endproperty
    a_hold: assert property (p_hold) else $error("Leadoff changed mid access.");
    // The longest leadoff of any setting bounds the first beat.
    property p_lead; $rose(access_busy_o) |-> ##[0:20] data_beat_o; endproperty
    a_lead: assert property (p_lead) else $error("First beat too late.");
    property p_gap; data_beat_o && !access_done_o |-> ##[1:3] data_beat_o; endproperty
    a_gap: assert property (p_gap) else $error("Burst beat spacing too long.");
    // Busy drops in the cycle of the last beat, together with done.
    property p_done; access_done_o |-> data_beat_o && !access_busy_o; endproperty
    a_done: assert property (p_done) else $error("Done not on last beat.");
    property p_idle;
        !access_busy_o && !$past(access_busy_o) |-> !data_beat_o && !access_done_o;
    endproperty
    a_idle: assert property (p_idle) else $error("Beat while idle.");
endmodule

// [dtc_front_model.sv]
// Behavioural memory front end that issues accesses and times the beats.
// Assumes the block takes a request at an edge where busy is low.
`timescale 1ns/1ps
module dtc_front_model (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic go_i,
    input wire logic busy_i,
    input wire logic beat_i,
    input wire logic done_i,
    output logic req_o,
    output logic fin_o,
    output logic odd_o,
    output logic [7:0] lead_o,
    output logic [7:0] gap_o,
    output logic [2:0] beats_o
);
    logic run;
    logic [7:0] cnt;
    logic [7:0] last;
    ////////////////////////////////////////////////
    // Request held until taken; uneven spacing or a stray done marks odd.
    always @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            req_o <= 1'b0;
            run <= 1'b0;
            fin_o <= 1'b0;
        end else if (go_i) begin
            req_o <= 1'b1;
            fin_o <= 1'b0;
            odd_o <= 1'b0;
            beats_o <= 3'h0;
        end else if (req_o && !busy_i) begin
            req_o <= 1'b0;
            run <= 1'b1;
            // Count from busy rising; the beat flop lags the count by one.
            cnt <= 8'h00;
        end else if (run) begin
            cnt <= cnt + 8'h01;
            if (beat_i) begin
                beats_o <= beats_o + 3'h1;
                last <= cnt;
                if (beats_o == 3'h0) lead_o <= cnt;
                else if (beats_o == 3'h1) gap_o <= cnt - last;
                else if (cnt - last != gap_o) odd_o <= 1'b1;
                if (done_i != (beats_o == 3'h3)) odd_o <= 1'b1;
                if (done_i) run <= 1'b0;
                if (done_i) fin_o <= 1'b1;
            end
        end
    end
endmodule

// [tb.sv]
// Testbench: register access over APB and timed accesses for many settings.
// Assumes the front end model drives the request and reports the timing.
`timescale 1ns/1ps
module tb;
    logic core_clk_i;
    logic sys_rst_i = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdat;
    logic pready, pslverr, rerr, req, busy, beat, done, fin, odd;
    logic wr = 1'b0;
    logic pipe = 1'b0;
    logic ras = 1'b0;
    logic go = 1'b0;
    logic [1:0] kind = 2'h0;
    logic [4:0] lc, e;
    logic [7:0] lead, gap, t, g;
    logic [2:0] beats;
    int n_errors = 0;
    int compares = 0;
    int cyc = 0;
    ////////////////////////////////////////////////
    dtc_timing_ctrl dut_u (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .access_req_i(req), .access_write_i(wr), .access_kind_i(kind),
        .access_pipelined_i(pipe), .access_ras_active_i(ras), .access_busy_o(busy),
        .data_beat_o(beat), .access_done_o(done), .leadoff_count_o(lc));
    dtc_front_model fm_u (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .go_i(go), .busy_i(busy),
        .beat_i(beat), .done_i(done), .req_o(req), .fin_o(fin), .odd_o(odd),
        .lead_o(lead), .gap_o(gap), .beats_o(beats));
    // Free running 20 MHz clock.
    initial begin
        core_clk_i = 1'b0;
        forever #25 core_clk_i = ~core_clk_i;
    end
    // A hung handshake ends the run instead of stalling it.
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_errors++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        if (n_errors == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; the request stands until pready is seen at an edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk_i);
        penable <= 1'b1;
        do @(posedge core_clk_i); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Expected leadoff: a base row plus each slower field, less a fast EDO RAS-to-CAS delay; slow CL takes one off a pipelined SDRAM page hit.
    function automatic logic [4:0] exp_lead(input logic sd, input logic ecc,
        input logic [7:0] tm, input logic [1:0] k, input logic p, input logic r);
        logic pm;
        logic rm;
        logic [4:0] n;
        pm = k[1];
        rm = (k == 2'h1);
        if (!sd) begin
            n = p ? (pm ? 5'h08 : rm ? 5'h06 : 5'h02) : (pm ? 5'h0D : rm ? 5'h0A : 5'h08);
            n = n + (tm[0] ? 5'h00 : (p || !(pm || rm)) ? 5'h01 : 5'h02);
            n = n - {4'h0, tm[1] & (pm | rm)};
            n = n + {4'h0, !tm[2] & pm};
        end else begin
            n = p ? (pm ? 5'h05 : rm ? 5'h04 : 5'h02) : (pm ? 5'h0C : rm ? 5'h0A : 5'h08);
            n = (!tm[5] && p && !(pm || rm)) ? 5'h01 : n + {4'h0, !tm[5]};
            n = n + {4'h0, !tm[6] & (pm | rm)};
            n = n + {4'h0, !tm[7] & pm};
            n = n + (tm[0] ? 5'h00 : pm ? 5'h03 : rm ? 5'h02 : 5'h01);
        end
        return n + {4'h0, rm & r & !p} + {4'h0, ecc};
    endfunction
    // Reset values and refusals first, then every kind under many settings.
    initial begin
        repeat (20) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        apb(1'b0, dtc_pkg::ADDR_TIMING, 32'h0);
        chk(rdat, 32'h0);
        apb(1'b0, dtc_pkg::ADDR_CTRL, 32'h0);
        chk(rdat, 32'h0);
        apb(1'b1, dtc_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
        apb(1'b0, dtc_pkg::ADDR_STATUS, 32'h0);
        chk(rdat, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk({rdat[30:0], rerr}, 32'h1);
        for (int i = 0; i < 64; i++) begin
            t = 8'(i * 73);
            // EDO runs mostly keep the 3-clock RAS-to-CAS delay.
            if (!i[4] && !i[0]) t[1] = 1'b0;
            apb(1'b1, dtc_pkg::ADDR_CTRL, {30'h0, i[5], i[4]});
            for (int j = 0; j < 8; j++) begin
                apb(1'b1, dtc_pkg::ADDR_TIMING, {24'h0, t});
                apb(1'b0, dtc_pkg::ADDR_TIMING, 32'h0);
                chk(rdat, {24'h0, t});
                @(posedge core_clk_i);
                kind <= j[1:0];
                pipe <= j[2];
                ras <= i[2];
                wr <= j[0] ^ i[3];
                go <= 1'b1;
                @(posedge core_clk_i);
                go <= 1'b0;
                apb(1'b1, dtc_pkg::ADDR_TIMING, {24'h0, ~t});
                while (fin !== 1'b1) @(posedge core_clk_i);
                e = exp_lead(i[4], i[5], t, j[1:0], j[2], i[2]);
                g = i[4] ? 8'h01 : (((j[0] ^ i[3]) ? t[4] : t[3]) ? 8'h02 : 8'h03);
                chk({24'h0, lead}, {27'h0, e});
                chk({24'h0, gap}, {24'h0, g});
                chk({28'h0, odd, beats}, 32'h4);
                chk({27'h0, lc}, {27'h0, e});
                apb(1'b0, dtc_pkg::ADDR_STATUS, 32'h0);
                chk(rdat, {19'h0, e, 8'h00});
            end
        end
        end_of_test();
    end
endmodule
bind dtc_timing_ctrl dtc_timing_monitor mon_u (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .access_req_i(access_req_i),
    .access_busy_o(access_busy_o), .data_beat_o(data_beat_o),
    .access_done_o(access_done_o), .leadoff_count_o(leadoff_count_o));
